// ===== amf_pkg.sv
// Package for the converter mode control and result formatting block
package amf_pkg;
    localparam int RES_W = 12;
    localparam int MODE_W = 4;
    localparam int MODE_CAL_BIT = 3;
    localparam int MODE_PWR_BIT = 2;
    localparam int SAR_CNT_W = 4;
    localparam logic [1:0] RES_10 = 2'h0;
    localparam logic [1:0] RES_12 = 2'h1;
    localparam logic [1:0] RES_8 = 2'h2;
    localparam logic [SAR_CNT_W-1:0] BITS_8 = 4'h8;
    localparam logic [SAR_CNT_W-1:0] BITS_10 = 4'ha;
    localparam logic [SAR_CNT_W-1:0] BITS_12 = 4'hc;
    localparam logic [1:0] CAL_CYCLES = 2'h2;
    localparam logic [3:0] PAD_8 = 4'h0;
    localparam logic [1:0] PAD_10 = 2'h0;

    typedef enum logic [2:0] {
        AMF_OFF = 3'b000,
        AMF_IDLE = 3'b001,
        AMF_CONV = 3'b010,
        AMF_CAL = 3'b011
    } amf_state_t;

    typedef struct packed {
        logic calib_off;
        logic stay_powered;
        logic [1:0] res_sel;
    } amf_mode_t;

    typedef struct packed {
        logic [RES_W-1:0] result;
        logic done;
    } amf_out_t;

    typedef struct packed {
        amf_state_t state;
        amf_mode_t mode;
        logic [SAR_CNT_W-1:0] bit_cnt;
        logic [1:0] cal_cnt;
        logic [RES_W-1:0] sar;
        logic busy;
        logic calibrating;
        logic analog_on;
        amf_out_t out;
    } amf_regs_t;
endpackage

// ===== amf_adc_ctrl.sv
// Mode control, conversion sequencing and result alignment for the SAR converter
//
// Behaviour
// - Comparator power-off gates only the comparators; sequencing logic keeps running.
// - Mode bit 3 low: two converter-clock calibration cycles follow each conversion.
// - Mode bit 2 low: converter powers down after each conversion.
// - Mode bits 1:0 pick 10, 12 or 8 bits; code 11 converts as 10 bits.
// - Every conversion appears on a twelve-bit result bus.
// - 8-bit values fill result bits 11:4; bits 3:0 are zero.
// - 10-bit values fill result bits 11:2; bits 1:0 are zero.
`timescale 1ns/1ps
module amf_adc_ctrl
    import amf_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic converter_clock,
    input wire logic start,
    input wire logic [MODE_W-1:0] mode,
    input wire logic comparator_power_off,
    input wire logic comp_decision,
    output logic comparator_enable,
    output logic analog_powered,
    output logic busy,
    output logic calibrating,
    output logic data_valid,
    output logic [RES_W-1:0] result
);
    amf_regs_t r_reg;
    amf_regs_t r_next;
    logic [SAR_CNT_W-1:0] nbits;
    logic [RES_W-1:0] aligned;
    logic [RES_W-1:0] sar_step;

    // Bit count for the held resolution
    always_comb begin
        unique case (r_reg.mode.res_sel)
            RES_12: nbits = BITS_12;
            RES_8: nbits = BITS_8;
            default: nbits = BITS_10;
        endcase
    end

    // Converter clock is treated as a synchronous one-cycle step enable
    always_comb begin
        r_next = r_reg;
        r_next.out.done = 1'b0;
        // Word with this step's decision placed; decisions fill from the top bit down
        sar_step = r_reg.sar;
        if (r_reg.bit_cnt < BITS_12) begin
            sar_step[RES_W-1-r_reg.bit_cnt] = comp_decision;
        end
        aligned = sar_step;
        unique case (r_reg.mode.res_sel)
            RES_8: aligned = {sar_step[RES_W-1:$bits(PAD_8)], PAD_8};
            RES_12: aligned = sar_step;
            default: aligned = {sar_step[RES_W-1:$bits(PAD_10)], PAD_10};
        endcase
        unique case (r_reg.state)
            AMF_OFF, AMF_IDLE: begin
                if (start) begin
                    r_next.mode = mode;
                    r_next.state = AMF_CONV;
                    r_next.bit_cnt = '0;
                    r_next.sar = '0;
                    r_next.busy = 1'b1;
                    r_next.analog_on = 1'b1;
                end
            end
            AMF_CONV: begin
                if (converter_clock) begin
                    r_next.sar = sar_step;
                    r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
                    if (r_reg.bit_cnt + 4'h1 == nbits) begin
                        r_next.out.done = 1'b1;
                        r_next.out.result = aligned;
                        if (!r_reg.mode.calib_off) begin
                            r_next.state = AMF_CAL;
                            r_next.cal_cnt = '0;
                            r_next.calibrating = 1'b1;
                        end else begin
                            r_next.busy = 1'b0;
                            r_next.analog_on = r_reg.mode.stay_powered;
                            r_next.state = r_reg.mode.stay_powered ? AMF_IDLE : AMF_OFF;
                        end
                    end
                end
            end
            AMF_CAL: begin
                if (converter_clock) begin
                    r_next.cal_cnt = r_reg.cal_cnt + 2'h1;
                    if (r_reg.cal_cnt + 2'h1 == CAL_CYCLES) begin
                        r_next.calibrating = 1'b0;
                        r_next.busy = 1'b0;
                        r_next.analog_on = r_reg.mode.stay_powered;
                        r_next.state = r_reg.mode.stay_powered ? AMF_IDLE : AMF_OFF;
                    end
                end
            end
            default: r_next.state = AMF_OFF;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r_reg <= '{state: AMF_OFF, mode: '0, bit_cnt: '0, cal_cnt: '0, sar: '0,
                       busy: 1'b0, calibrating: 1'b0, analog_on: 1'b0, out: '0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign comparator_enable = r_reg.analog_on & ~comparator_power_off;
    assign analog_powered = r_reg.analog_on;
    assign busy = r_reg.busy;
    assign calibrating = r_reg.calibrating;
    assign data_valid = r_reg.out.done;
    assign result = r_reg.out.result;

    property p_pad8;
        @(posedge clk) disable iff (!nrst)
        (data_valid && r_reg.mode.res_sel == RES_8) |-> result[3:0] == PAD_8;
    endproperty
    a_pad8: assert property (p_pad8) else $error("8-bit low nibble not zero");

    property p_pad10;
        @(posedge clk) disable iff (!nrst)
        (data_valid && r_reg.mode.res_sel == RES_10) |-> result[1:0] == PAD_10;
    endproperty
    a_pad10: assert property (p_pad10) else $error("10-bit low bits not zero");

    property p_cal;
        @(posedge clk) disable iff (!nrst)
        (data_valid && !r_reg.mode.calib_off) |-> calibrating && busy;
    endproperty
    a_cal: assert property (p_cal) else $error("calibration did not follow");

    property p_nocal;
        @(posedge clk) disable iff (!nrst)
        (data_valid && r_reg.mode.calib_off) |-> !calibrating && !busy;
    endproperty
    a_nocal: assert property (p_nocal) else $error("unexpected calibration");

    property p_pwr;
        @(posedge clk) disable iff (!nrst)
        ($fell(busy) && !r_reg.mode.stay_powered) |-> !analog_powered;
    endproperty
    a_pwr: assert property (p_pwr) else $error("no power-down after conversion");

    property p_keep;
        @(posedge clk) disable iff (!nrst)
        ($fell(busy) && r_reg.mode.stay_powered) |-> analog_powered;
    endproperty
    a_keep: assert property (p_keep) else $error("powered down while held on");

    property p_hold;
        @(posedge clk) disable iff (!nrst)
        (busy && $past(busy)) |-> $stable(r_reg.mode);
    endproperty
    a_hold: assert property (p_hold) else $error("mode changed mid conversion");

    property p_comp;
        @(posedge clk) disable iff (!nrst)
        comparator_power_off |-> !comparator_enable;
    endproperty
    a_comp: assert property (p_comp) else $error("comparators not gated");

    property p_code;
        @(posedge clk) disable iff (!nrst)
        busy |-> r_reg.mode.res_sel != 2'h3;
    endproperty
    a_code: assert property (p_code) else $error("unused resolution code");

    property p_run_off;
        @(posedge clk) disable iff (!nrst)
        (comparator_power_off && start && !busy) |=> busy;
    endproperty
    a_run_off: assert property (p_run_off) else $error("start lost while comparators off");

    property p_take;
        @(posedge clk) disable iff (!nrst)
        (start && !busy) |=> busy && analog_powered && (r_reg.mode == amf_mode_t'($past(mode)));
    endproperty
    a_take: assert property (p_take) else $error("start not taken with its mode");

    property p_conv_end;
        @(posedge clk) disable iff (!nrst)
        (r_reg.state == AMF_CONV && converter_clock && r_reg.bit_cnt == nbits - 4'h1) |=> data_valid;
    endproperty
    a_conv_end: assert property (p_conv_end) else $error("result missing after last step");

    property p_cal_end;
        @(posedge clk) disable iff (!nrst)
        (calibrating && converter_clock && r_reg.cal_cnt == CAL_CYCLES - 2'h1) |=> !calibrating && !busy;
    endproperty
    a_cal_end: assert property (p_cal_end) else $error("calibration length wrong");

    property p_valid_len;
        @(posedge clk) disable iff (!nrst)
        data_valid |=> !data_valid;
    endproperty
    a_valid_len: assert property (p_valid_len) else $error("result strobe longer than one cycle");

    property p_result_hold;
        @(posedge clk) disable iff (!nrst)
        !data_valid |-> $stable(result);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("result changed without a conversion");

    c_8: cover property (@(posedge clk) data_valid && r_reg.mode.res_sel == RES_8);
    c_12: cover property (@(posedge clk) data_valid && r_reg.mode.res_sel == RES_12);
    c_calend: cover property (@(posedge clk) $fell(calibrating));
    c_off: cover property (@(posedge clk) $fell(analog_powered));
    c_run_off: cover property (@(posedge clk) comparator_power_off && start && !busy);
endmodule

// ===== amf_comp_model.sv
// Comparator model feeding one target value, most significant bit first
`timescale 1ns/1ps
module amf_comp_model
    import amf_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic converter_clock,
    input wire logic busy,
    input wire logic calibrating,
    input wire logic comparator_enable,
    input wire logic [RES_W-1:0] value,
    output logic comp_decision
);
    logic [SAR_CNT_W-1:0] idx_reg;
    logic toggle_reg;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            idx_reg <= '0;
            toggle_reg <= 1'b0;
        end else begin
            toggle_reg <= ~toggle_reg;
            if (!busy) begin
                idx_reg <= '0;
            end else if (converter_clock && !calibrating && idx_reg < BITS_12) begin
                idx_reg <= idx_reg + 4'h1;
            end
        end
    end
    // Gated comparators decide nothing
    // Toggling pattern so a stale bit can never pass as a match
    assign comp_decision = (comparator_enable && idx_reg < BITS_12) ? value[RES_W-1-int'(idx_reg)] : toggle_reg;
endmodule

// ===== amf_adc_ctrl_tb.sv
// Self-checking bench for the converter mode control block
`timescale 1ns/1ps
module amf_adc_ctrl_tb;
    import amf_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic converter_clock = 1'b0;
    logic start = 1'b0;
    logic [MODE_W-1:0] mode = 4'h0;
    logic [MODE_W-1:0] m;
    logic comparator_power_off = 1'b0;
    logic [RES_W-1:0] value = 12'h000;
    logic comp_decision, comparator_enable, analog_powered, busy, calibrating, data_valid;
    logic [RES_W-1:0] result;
    logic [RES_W-1:0] exp_q[$];
    logic cal_seen = 1'b0;
    int seed = 12;
    int n_errors = 0;
    int check_count = 0;
    int i, k;
    always #25 clk = ~clk;
    amf_adc_ctrl u_amf_adc_ctrl(.clk(clk), .nrst(nrst), .converter_clock(converter_clock), .start(start),
        .mode(mode), .comparator_power_off(comparator_power_off), .comp_decision(comp_decision),
        .comparator_enable(comparator_enable), .analog_powered(analog_powered), .busy(busy),
        .calibrating(calibrating), .data_valid(data_valid), .result(result));
    amf_comp_model u_amf_comp_model(.clk(clk), .nrst(nrst), .converter_clock(converter_clock), .busy(busy),
        .calibrating(calibrating), .comparator_enable(comparator_enable), .value(value),
        .comp_decision(comp_decision));
    task automatic check(input string name, input logic [RES_W-1:0] seen, input logic [RES_W-1:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        if (n_errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Outputs are looked at just after the launching edge, once they have settled
    always @(posedge clk) begin
        #1;
        if (nrst && data_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("extra_result", 12'h001, 12'h000);
            end else begin
                check("result", result, exp_q.pop_front());
            end
        end
        if (calibrating === 1'b1) begin
            cal_seen = 1'b1;
        end
        // Converter is powered through a whole conversion, so only the power-off pin gates it then
        if (nrst && busy === 1'b1) begin
            check("cmp_en", 12'(comparator_enable), 12'(!comparator_power_off));
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        for (i = 0; i < 24; i++) begin
            // Only legal resolution codes, every one of them
            mode = {1'((i / 3) % 2), 1'((i / 6) % 2), 2'(i % 3)};
            m = mode;
            value = 12'($random(seed));
            case (m[1:0])
                RES_8: exp_q.push_back({value[11:4], PAD_8});
                RES_10: exp_q.push_back({value[11:2], PAD_10});
                default: exp_q.push_back(value);
            endcase
            @(negedge clk);
            // A start must be taken even with the comparators switched off
            comparator_power_off = 1'($random(seed));
            start = 1'b1;
            @(negedge clk);
            comparator_power_off = 1'b0;
            // Mode changes and a second start mid-conversion must both be ignored
            mode = {~m[3:2], (m[1:0] == RES_12) ? RES_8 : RES_12};
            cal_seen = 1'b0;
            for (k = 0; k < 200 && busy !== 1'b0; k++) begin
                @(negedge clk);
                if (busy === 1'b1) begin
                    start = 1'b0;
                    converter_clock = 1'($random(seed));
                    // Comparators may be off during calibration without stalling it
                    comparator_power_off = (calibrating === 1'b1) ? 1'($random(seed)) : 1'b0;
                end
            end
            converter_clock = 1'b0;
            comparator_power_off = 1'($random(seed));
            if (k == 200) begin
                check("busy_timeout", 12'h001, 12'h000);
                break;
            end
            @(negedge clk);
            check("powered_after", 12'(analog_powered), 12'(m[MODE_PWR_BIT]));
            check("cmp_idle", 12'(comparator_enable), 12'(m[MODE_PWR_BIT] && !comparator_power_off));
            check("cal_seen", 12'(cal_seen), 12'(!m[MODE_CAL_BIT]));
            check("pending", 12'(exp_q.size()), 12'h000);
        end
        // Reset in mid-conversion must return busy, power, valid, result and comparator enable to their reset values
        mode = {2'h0, RES_12};
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        converter_clock = 1'b1;
        repeat (3) @(negedge clk);
        nrst = 1'b0;
        converter_clock = 1'b0;
        @(negedge clk);
        check("rst_busy", 12'(busy), 12'h000);
        check("rst_powered", 12'(analog_powered), 12'h000);
        check("rst_valid", 12'(data_valid), 12'h000);
        check("rst_result", result, 12'h000);
        nrst = 1'b1;
        @(negedge clk);
        check("rst_cmp_en", 12'(comparator_enable), 12'h000);
        tally_and_finish();
    end
endmodule
